/* hw/fcd_crc16.sv */
// Purpose: Running RTU error-check register, one byte per enable.
// Assumes: Clear and enable never meet; clear wins if they do.
// Notes:   Feeding a frame and its two check bytes leaves zero.
`default_nettype none
`timescale 1ns/1ps

module fcd_crc16 (
  input  wire logic        clk,
  input  wire logic        rstSync_n,
  input  wire logic        clear,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  output logic      [15:0] crc
);

  logic [15:0] st;
  logic [15:0] next_st;

  // ==========================================================
  // Reflected polynomial, LSB first
  // ==========================================================
  always_comb
  begin
    next_st = st;
    if (clear)
    begin
      next_st = fcd_pkg::CRC_INIT;
    end
    else if (en)
    begin
      next_st = st ^ {8'h00, data};
      for (int b = 0; b < 8; b++)
      begin
        next_st = next_st[0] ? ((next_st >> 1) ^ fcd_pkg::CRC_POLY) : (next_st >> 1);
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      st <= fcd_pkg::CRC_INIT;
    else
      st <= next_st;
  end

  assign crc = st;

endmodule : fcd_crc16

`default_nettype wire

/* hw/fcd_decoder.sv */
// Purpose: Follower handler for multi-register preset and read/write,
//          plus the drive command word decoder.
// Assumes: UART on clk delivers bytes and an end-of-frame pulse.
// Notes:   Bad or foreign frames are dropped with no reply.
`default_nettype none
`timescale 1ns/1ps

// Functional notes
// - Function 10h writes consecutive registers; data high byte first, then CRC.
// - Wire register address is register number minus one.
// - Preset reply: address, function, start, count, CRC; no data.
// - Function 17h does one read and one write per transaction.
// - Write completes before read; overlapping reads see new values.
// - Read/write reply: address, function, byte count, read data, CRC.
// - A 32-bit parameter spans two registers, accessed with count two.
// - Bits 1..0 select one of four preset references.
// - Bit 2 low: DC brake for configured time and current, then stop.
// - Bit 3 low: output stage off, motor coasts.
// - Bit 4 low: quick-stop ramp to standstill.
// - Bit 5 low: output frequency frozen, trimmed only by inputs.
// - While frozen, only coast, DC brake or their inputs stop.
// - Bit 6 low: ramp stop; high allows start.
// - Trip reset only on rising edge of bit 7.
// - Bits 8..15: jog, ramp 2, valid, relays, set-up, reverse.
// - Preset, coast and start bits combine with inputs per setting.
// - Bit 10 low: whole command word ignored.
module fcd_decoder #(
  parameter int          DEPTH       = 64,
  parameter int          MAXQ        = 8,
  parameter logic [15:0] CMD_ADDR    = fcd_pkg::CMD_WORD_ADDR,
  parameter int unsigned TICK_CYCLES = fcd_pkg::TICK_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [7:0]             followerAddr,
  input  wire logic [7:0]             rxByte,
  input  wire logic                   rxValid,
  input  wire logic                   rxFrameEnd,
  output logic      [7:0]             txByte,
  output logic                        txValid,
  input  wire logic                   txReady,
  input  wire fcd_pkg::fcd_din_t      din,
  input  wire fcd_pkg::fcd_sel_cfg_t  selCfg,
  input  wire logic [7:0]             dcHoldCurrent,
  input  wire logic [15:0]            dcHoldDuration,
  output fcd_pkg::fcd_drive_cmd_t     cmd,
  output logic      [7:0]             dcCurrentCmd
);

  localparam int AW = $clog2(DEPTH);
  localparam int KW = $clog2(2 * MAXQ) + 1;
  localparam int TW = $clog2(TICK_CYCLES + 1);

  // ==========
  // Elaboration checks
  // ==========
  if (DEPTH < 2 || MAXQ < 1 || MAXQ > 64 || TICK_CYCLES < 1)
  begin : g_bad_param
    $error("fcd_decoder: unsupported parameter value");
  end

  typedef enum logic [2:0] {
    FCD_RX    = 3'h0,
    FCD_WRITE = 3'h1,
    FCD_READ  = 3'h2,
    FCD_RCAP  = 3'h3,
    FCD_TX    = 3'h4
  } fcd_phase_t;

  typedef struct packed {
    fcd_phase_t             phase;
    logic [7:0]             byteIdx;
    logic                   bad;
    logic [7:0]             func;
    logic [15:0]            rStart;
    logic [15:0]            rQty;
    logic [15:0]            wStart;
    logic [15:0]            wQty;
    logic [7:0]             bc;
    logic [MAXQ-1:0][15:0]  dat;
    logic [7:0]             idx;
    logic                   cmdHit;
    logic [15:0]            cmdNew;
    logic [15:0]            cmdWord;
    logic [7:0]             txIdx;
    logic [7:0]             txByte;
    logic                   txValid;
    fcd_pkg::fcd_din_t      din1;
    fcd_pkg::fcd_din_t      din2;
    fcd_pkg::fcd_drive_cmd_t cmd;
    logic                   dcReqOld;
    logic [15:0]            dcCount;
    logic [TW-1:0]          tickCnt;
    logic [7:0]             dcCurrentCmd;
  } fcd_state_t;

  localparam fcd_state_t ST_RESET = '{
    phase: FCD_RX, cmdWord: fcd_pkg::CMD_WORD_RESET, default: '0};

  fcd_state_t st;
  fcd_state_t next_st;
  logic [1:0] rstPipe;
  logic       rstSync_n;
  logic       crcClear;
  logic       crcRxEn;
  logic       crcTxEn;
  logic [15:0] rxCrc;
  logic [15:0] txCrc;
  logic          memWe;
  logic [AW-1:0] memWAddr;
  logic [15:0]   memWData;
  logic [AW-1:0] memRAddr;
  logic [15:0]   memRData;

  // ==========
  // Reset release through two flip-flops
  // ==========
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rstPipe <= 2'h0;
    else
      rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstSync_n = rstPipe[1];

  // Input select: digital input, bus, AND or OR
  function automatic logic fcd_mix(fcd_pkg::fcd_sel_t s, logic bus, logic pin);
    case (s)
      fcd_pkg::FCD_SEL_DIN: fcd_mix = pin;
      fcd_pkg::FCD_SEL_BUS: fcd_mix = bus;
      fcd_pkg::FCD_SEL_AND: fcd_mix = bus & pin;
      fcd_pkg::FCD_SEL_OR:  fcd_mix = bus | pin;
      default:              fcd_mix = pin;
    endcase
  endfunction : fcd_mix

  // ==========
  // Next-state logic
  // ==========
  always_comb
  begin
    logic [7:0]    dOff;
    logic [7:0]    k;
    logic [7:0]    hdr;
    logic [7:0]    dlen;
    logic [7:0]    d;
    logic [7:0]    b;
    logic [16:0]   wEnd;
    logic [16:0]   rEnd;
    logic          ok;
    logic          pm;
    logic [15:0]   cw;
    logic          noCoast;
    logic          start;
    logic          dcReq;
    dOff = '0;
    k = '0;
    hdr = '0;
    dlen = '0;
    d = '0;
    b = '0;
    wEnd = '0;
    rEnd = '0;
    ok = 1'b0;
    pm = 1'b0;
    cw = '0;
    noCoast = 1'b0;
    start = 1'b0;
    dcReq = 1'b0;
    next_st = st;
    crcClear = 1'b0;
    crcRxEn = 1'b0;
    crcTxEn = 1'b0;
    memWe = 1'b0;
    memWAddr = st.wStart[AW-1:0] + st.idx[AW-1:0];
    memWData = st.dat[st.idx[KW-2:0]];
    memRAddr = st.rStart[AW-1:0] + st.idx[AW-1:0];
    next_st.cmd.tripReset = 1'b0;
    pm = (st.func == fcd_pkg::FUNC_PRESET_MULTI);
    dOff = pm ? fcd_pkg::PM_DATA : fcd_pkg::RW_DATA;

    // Query intake; field order differs per function
    case (st.phase)
      FCD_RX:
      begin
        if (rxValid)
        begin
          crcRxEn = 1'b1;
          if (st.byteIdx != 8'hFF)
            next_st.byteIdx = st.byteIdx + 8'h01;
          k = st.byteIdx - dOff;
          if (st.byteIdx == fcd_pkg::IDX_ADDR)
            next_st.bad = (rxByte != followerAddr);
          else if (st.byteIdx == fcd_pkg::IDX_FUNC)
            next_st.func = rxByte;
          else if (st.byteIdx >= dOff)
          begin
            // Data bytes pair high then low into one register
            if (k < 8'(2 * MAXQ))
            begin
              if (!k[0])
                next_st.dat[k[KW-1:1]][15:8] = rxByte;
              else
                next_st.dat[k[KW-1:1]][7:0] = rxByte;
            end
          end
          else if (pm)
          begin
            case (st.byteIdx)
              fcd_pkg::IDX_F2: next_st.wStart[15:8] = rxByte;
              fcd_pkg::IDX_F3: next_st.wStart[7:0] = rxByte;
              fcd_pkg::IDX_F4: next_st.wQty[15:8] = rxByte;
              fcd_pkg::IDX_F5: next_st.wQty[7:0] = rxByte;
              fcd_pkg::IDX_F6: next_st.bc = rxByte;
              default: next_st.bad = st.bad;
            endcase
          end
          else
          begin
            case (st.byteIdx)
              fcd_pkg::IDX_F2:  next_st.rStart[15:8] = rxByte;
              fcd_pkg::IDX_F3:  next_st.rStart[7:0] = rxByte;
              fcd_pkg::IDX_F4:  next_st.rQty[15:8] = rxByte;
              fcd_pkg::IDX_F5:  next_st.rQty[7:0] = rxByte;
              fcd_pkg::IDX_F6:  next_st.wStart[15:8] = rxByte;
              fcd_pkg::IDX_F7:  next_st.wStart[7:0] = rxByte;
              fcd_pkg::IDX_F8:  next_st.wQty[15:8] = rxByte;
              fcd_pkg::IDX_F9:  next_st.wQty[7:0] = rxByte;
              fcd_pkg::IDX_F10: next_st.bc = rxByte;
              default: next_st.bad = st.bad;
            endcase
          end
        end
        else if (rxFrameEnd)
        begin
          // Validate the whole frame before touching any register
          wEnd = {1'b0, st.wStart} + {1'b0, st.wQty};
          rEnd = {1'b0, st.rStart} + {1'b0, st.rQty};
          ok = !st.bad && (rxCrc == 16'h0000)
             && (st.byteIdx == dOff + st.bc + fcd_pkg::CRC_BYTES)
             && (st.wQty != 16'h0000) && (st.wQty <= 16'(MAXQ))
             && ({8'h00, st.bc} == {st.wQty[14:0], 1'b0})
             && (wEnd <= 17'(DEPTH));
          if (!pm)
            ok = ok && (st.func == fcd_pkg::FUNC_READ_WRITE)
               && (st.rQty != 16'h0000) && (st.rQty <= 16'(MAXQ))
               && (rEnd <= 17'(DEPTH));
          crcClear = 1'b1;
          next_st.byteIdx = '0;
          next_st.bad = 1'b0;
          next_st.idx = '0;
          next_st.cmdHit = 1'b0;
          if (ok)
            next_st.phase = FCD_WRITE;
        end
      end

      // Write phase always precedes any read
      FCD_WRITE:
      begin
        memWe = 1'b1;
        if (st.wStart + 16'(st.idx) == CMD_ADDR)
        begin
          next_st.cmdHit = 1'b1;
          next_st.cmdNew = memWData;
        end
        next_st.idx = st.idx + 8'h01;
        if (16'(st.idx) + 16'h0001 == st.wQty)
        begin
          next_st.idx = '0;
          next_st.phase = pm ? FCD_TX : FCD_READ;
          // Word applied only when marked valid
          if (next_st.cmdHit && next_st.cmdNew[fcd_pkg::B_VALID])
          begin
            next_st.cmdWord = next_st.cmdNew;
            next_st.cmd.tripReset = next_st.cmdNew[fcd_pkg::B_RESET]
                                  & ~st.cmdWord[fcd_pkg::B_RESET];
          end
        end
      end

      // Read after write, two cycles per register
      FCD_READ:
      begin
        next_st.phase = FCD_RCAP;
      end

      FCD_RCAP:
      begin
        next_st.dat[st.idx[KW-2:0]] = memRData;
        next_st.idx = st.idx + 8'h01;
        next_st.phase = FCD_READ;
        if (16'(st.idx) + 16'h0001 == st.rQty)
          next_st.phase = FCD_TX;
      end

      // Reply, one byte per handshake
      FCD_TX:
      begin
        hdr = pm ? fcd_pkg::PM_HDR : fcd_pkg::RW_HDR;
        dlen = pm ? 8'h00 : {st.rQty[6:0], 1'b0};
        d = st.txIdx - hdr;
        if (st.txIdx < hdr)
        begin
          case (st.txIdx)
            fcd_pkg::IDX_ADDR: b = followerAddr;
            fcd_pkg::IDX_FUNC: b = st.func;
            fcd_pkg::IDX_F2:   b = pm ? st.wStart[15:8] : dlen;
            fcd_pkg::IDX_F3:   b = st.wStart[7:0];
            fcd_pkg::IDX_F4:   b = st.wQty[15:8];
            default:           b = st.wQty[7:0];
          endcase
        end
        else if (st.txIdx < hdr + dlen)
          b = d[0] ? st.dat[d[KW-1:1]][7:0] : st.dat[d[KW-1:1]][15:8];
        else if (st.txIdx == hdr + dlen)
          b = txCrc[7:0];
        else
          b = txCrc[15:8];
        if (!st.txValid)
        begin
          next_st.txByte = b;
          next_st.txValid = 1'b1;
          crcTxEn = (st.txIdx < hdr + dlen);
        end
        else if (txReady)
        begin
          next_st.txValid = 1'b0;
          next_st.txIdx = st.txIdx + 8'h01;
          if (st.txIdx == hdr + dlen + 8'h01)
          begin
            next_st.txIdx = '0;
            crcClear = 1'b1;
            next_st.phase = FCD_RX;
          end
        end
      end

      default:
      begin
        next_st.phase = FCD_RX;
      end
    endcase

    // ==========
    // Command word decode, inputs synchronised through two flip-flops
    // ==========
    next_st.din1 = din;
    next_st.din2 = st.din1;
    cw = st.cmdWord;
    next_st.cmd.presetSel[0] = fcd_mix(selCfg.preset, cw[fcd_pkg::B_REF_LSB], st.din2.refSel[0]);
    next_st.cmd.presetSel[1] = fcd_mix(selCfg.preset, cw[fcd_pkg::B_REF_MSB], st.din2.refSel[1]);
    noCoast = fcd_mix(selCfg.coast, cw[fcd_pkg::B_NO_COAST], st.din2.noCoast);
    start = fcd_mix(selCfg.start, cw[fcd_pkg::B_START], st.din2.start);
    next_st.cmd.coast = ~noCoast | ~st.din2.coastResetInv_n;
    next_st.cmd.holdFreq = ~cw[fcd_pkg::B_USE_RAMP];
    // Freeze masks the ramped stops, coast and brake still act
    next_st.cmd.quickStop = ~cw[fcd_pkg::B_NO_QSTOP] & cw[fcd_pkg::B_USE_RAMP];
    next_st.cmd.rampStop = ~start & cw[fcd_pkg::B_USE_RAMP];
    next_st.cmd.jog = cw[fcd_pkg::B_JOG];
    next_st.cmd.ramp2 = cw[fcd_pkg::B_RAMP2];
    next_st.cmd.relay1 = cw[fcd_pkg::B_RELAY1];
    next_st.cmd.relay2 = cw[fcd_pkg::B_RELAY2];
    next_st.cmd.setup = cw[fcd_pkg::B_SETUP_HI:fcd_pkg::B_SETUP_LO];
    next_st.cmd.reverse = cw[fcd_pkg::B_REVERSE];

    // DC brake: millisecond countdown, then hold stop
    dcReq = ~cw[fcd_pkg::B_NO_DC] | ~st.din2.dcBrakeInv_n;
    next_st.dcReqOld = dcReq;
    next_st.tickCnt = st.tickCnt + TW'(1);
    if (st.tickCnt == TW'(TICK_CYCLES - 1))
      next_st.tickCnt = '0;
    if (dcReq && !st.dcReqOld)
    begin
      next_st.dcCount = dcHoldDuration;
      next_st.tickCnt = '0;
    end
    else if (!dcReq)
      next_st.dcCount = '0;
    else if (st.tickCnt == TW'(TICK_CYCLES - 1) && st.dcCount != 16'h0000)
      next_st.dcCount = st.dcCount - 16'h0001;
    next_st.cmd.dcBrake = dcReq && (next_st.dcCount != 16'h0000);
    next_st.cmd.dcStop = dcReq && (next_st.dcCount == 16'h0000);
    next_st.dcCurrentCmd = next_st.cmd.dcBrake ? dcHoldCurrent : 8'h00;
  end

  // ==========
  // State register
  // ==========
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      st <= ST_RESET;
    else
      st <= next_st;
  end

  // Check sequence over incoming query
  fcd_crc16 u_rxCrc (
    .clk       (clk),
    .rstSync_n (rstSync_n),
    .clear     (crcClear),
    .en        (crcRxEn),
    .data      (rxByte),
    .crc       (rxCrc)
  );

  // Check sequence over outgoing reply
  fcd_crc16 u_txCrc (
    .clk       (clk),
    .rstSync_n (rstSync_n),
    .clear     (crcClear),
    .en        (crcTxEn),
    .data      (next_st.txByte),
    .crc       (txCrc)
  );

  fcd_regmem #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .clk    (clk),
    .wrEn   (memWe),
    .wrAddr (memWAddr),
    .wrData (memWData),
    .rdAddr (memRAddr),
    .rdData (memRData)
  );

  // Outputs straight from the state register
  assign txByte = st.txByte;
  assign txValid = st.txValid;
  assign cmd = st.cmd;
  assign dcCurrentCmd = st.dcCurrentCmd;

endmodule : fcd_decoder

`default_nettype wire

/* hw/fcd_regmem.sv */
// Purpose: Holding register store, one write and one read port.
// Assumes: Index equals the zero-based wire address.
// Notes:   Read data appear one cycle after the address, registered.
`default_nettype none
`timescale 1ns/1ps

module fcd_regmem #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          clk,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [15:0]   wrData,
  input  wire logic [AW-1:0] rdAddr,
  output logic      [15:0]   rdData
);

  logic [15:0] mem [DEPTH];

  // ==========================================================
  // Storage; contents carry no reset, like any RAM
  // ==========================================================
  always_ff @(posedge clk)
  begin
    if (wrEn)
      mem[wrAddr] <= wrData;
    rdData <= mem[rdAddr];
  end

endmodule : fcd_regmem

`default_nettype wire

/* include/fcd_pkg.sv */
// Purpose: Shared constants and types for the fieldbus command decoder.
// Assumes: 20 MHz system clock, RTU byte stream delivered by a UART.
// Notes:   Frame positions count from the follower address byte (0).
`default_nettype none

package fcd_pkg;

  // ==========
  // Function codes and error check
  // ==========
  localparam logic [7:0]  FUNC_PRESET_MULTI = 8'h10;
  localparam logic [7:0]  FUNC_READ_WRITE   = 8'h17;
  localparam logic [15:0] CRC_INIT          = 16'hFFFF;
  localparam logic [15:0] CRC_POLY          = 16'hA001;

  // ==========
  // Query and reply byte positions
  // ==========
  localparam logic [7:0] IDX_ADDR  = 8'h00;
  localparam logic [7:0] IDX_FUNC  = 8'h01;
  localparam logic [7:0] IDX_F2    = 8'h02;
  localparam logic [7:0] IDX_F3    = 8'h03;
  localparam logic [7:0] IDX_F4    = 8'h04;
  localparam logic [7:0] IDX_F5    = 8'h05;
  localparam logic [7:0] IDX_F6    = 8'h06;
  localparam logic [7:0] IDX_F7    = 8'h07;
  localparam logic [7:0] IDX_F8    = 8'h08;
  localparam logic [7:0] IDX_F9    = 8'h09;
  localparam logic [7:0] IDX_F10   = 8'h0A;
  localparam logic [7:0] PM_DATA   = 8'h07;
  localparam logic [7:0] RW_DATA   = 8'h0B;
  localparam logic [7:0] PM_HDR    = 8'h06;
  localparam logic [7:0] RW_HDR    = 8'h03;
  localparam logic [7:0] CRC_BYTES = 8'h02;

  // ==========
  // Command word bit positions and reset value
  // ==========
  localparam int B_REF_LSB  = 0;
  localparam int B_REF_MSB  = 1;
  localparam int B_NO_DC    = 2;
  localparam int B_NO_COAST = 3;
  localparam int B_NO_QSTOP = 4;
  localparam int B_USE_RAMP = 5;
  localparam int B_START    = 6;
  localparam int B_RESET    = 7;
  localparam int B_JOG      = 8;
  localparam int B_RAMP2    = 9;
  localparam int B_VALID    = 10;
  localparam int B_RELAY1   = 11;
  localparam int B_RELAY2   = 12;
  localparam int B_SETUP_LO = 13;
  localparam int B_SETUP_HI = 14;
  localparam int B_REVERSE  = 15;
  // Ramp-stopped, no brake, no coast: a safe idle word
  localparam logic [15:0] CMD_WORD_RESET = 16'h003C;
  localparam logic [15:0] CMD_WORD_ADDR  = 16'h0000;

  // ==========
  // Timing
  // ==========
  localparam int unsigned CLK_NS      = 50;
  localparam int unsigned DC_TICK_NS  = 1000000;
  localparam int unsigned TICK_CYCLES = DC_TICK_NS / CLK_NS;

  // ==========
  // Types
  // ==========
  typedef enum logic [1:0] {
    FCD_SEL_DIN = 2'h0,
    FCD_SEL_BUS = 2'h1,
    FCD_SEL_AND = 2'h2,
    FCD_SEL_OR  = 2'h3
  } fcd_sel_t;

  typedef struct packed {
    fcd_sel_t preset;
    fcd_sel_t coast;
    fcd_sel_t start;
  } fcd_sel_cfg_t;

  typedef struct packed {
    logic [1:0] refSel;
    logic       noCoast;
    logic       start;
    logic       dcBrakeInv_n;
    logic       coastResetInv_n;
  } fcd_din_t;

  typedef struct packed {
    logic [1:0] presetSel;
    logic       dcBrake;
    logic       dcStop;
    logic       coast;
    logic       quickStop;
    logic       holdFreq;
    logic       rampStop;
    logic       tripReset;
    logic       jog;
    logic       ramp2;
    logic       relay1;
    logic       relay2;
    logic [1:0] setup;
    logic       reverse;
  } fcd_drive_cmd_t;

endpackage : fcd_pkg

`default_nettype wire

/* test/fcd_decoder_assertions.sv */
// Purpose: Port-level checks of the command decoder.
// Assumes: Hold time of 3 ticks, 4 clocks each.
// Notes:   Bound to every decoder instance.
`timescale 1ns/1ps
`default_nettype none
module fcd_decoder_assertions (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic [7:0]              followerAddr,
  input wire logic                    rxFrameEnd,
  input wire logic [7:0]              txByte,
  input wire logic                    txValid,
  input wire logic                    txReady,
  input wire logic [7:0]              dcHoldCurrent,
  input wire fcd_pkg::fcd_drive_cmd_t cmd,
  input wire logic [7:0]              dcCurrentCmd
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // Reply progress
  logic sent;
  // Set by a taken byte, so only a reply's first byte is tied to the address
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) sent <= 1'b0;
    else if (rxFrameEnd || txValid && txReady) sent <= !rxFrameEnd;
  // ==========
  // Properties
  property p_hold; txValid && !txReady |=> txValid && $stable(txByte); endproperty
  a_hold: assert property (p_hold) else $error("reply byte lost");
  property p_lead; $rose(txValid) && !sent |-> txByte == followerAddr; endproperty
  a_lead: assert property (p_lead) else $error("reply not led by address");
  property p_gap; rxFrameEnd |=> !txValid [*2]; endproperty
  a_gap: assert property (p_gap) else $error("reply before write");
  property p_trip; cmd.tripReset |=> !cmd.tripReset; endproperty
  a_trip: assert property (p_trip) else $error("trip reset held");
  property p_freeze; cmd.holdFreq |-> !cmd.quickStop && !cmd.rampStop; endproperty
  a_freeze: assert property (p_freeze) else $error("stop while frozen");
  property p_excl; cmd.dcBrake |-> !cmd.dcStop; endproperty
  a_excl: assert property (p_excl) else $error("brake and stop together");
  property p_brake; $rose(cmd.dcBrake) |-> cmd.dcBrake [*8] ##[1:8] cmd.dcStop; endproperty
  a_brake: assert property (p_brake) else $error("brake time wrong");
  property p_cur; cmd.dcBrake && $past(cmd.dcBrake) |-> dcCurrentCmd == dcHoldCurrent; endproperty
  a_cur: assert property (p_cur) else $error("brake current wrong");
endmodule : fcd_decoder_assertions
bind fcd_decoder fcd_decoder_assertions fcd_decoder_assertions_inst (.clk, .rst_n, .followerAddr,
  .rxFrameEnd, .txByte, .txValid, .txReady, .dcHoldCurrent, .cmd, .dcCurrentCmd);
`default_nettype wire

/* test/fcd_master_model.sv */
// Purpose: Bus master sending queries and taking replies.
// Assumes: Bytes arrive whole from the bench, check bytes included.
// Notes:   Slow mode takes reply bytes every other cycle.
`timescale 1ns/1ps
`default_nettype none
module fcd_master_model (
  input  wire logic       clk,
  output logic      [7:0] rxByte,
  output logic            rxValid,
  output logic            rxFrameEnd,
  input  wire logic [7:0] txByte,
  input  wire logic       txValid,
  output logic            txReady
);
  logic       slow = 1'b0;
  logic [7:0] q[$];
  initial
  begin
    rxByte = 8'h00;
    rxValid = 1'b0;
    rxFrameEnd = 1'b0;
    txReady = 1'b1;
  end
  // ==========
  // Query, then the silence marker
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i])
    begin
      @(negedge clk);
      rxByte = f[i];
      rxValid = 1'b1;
      @(negedge clk);
      rxValid = 1'b0;
      rxByte = ~rxByte; // Idle line must not echo the byte
    end
    @(negedge clk);
    rxFrameEnd = 1'b1;
    @(negedge clk);
    rxFrameEnd = 1'b0;
  endtask : send
  // Reply capture and pacing
  always @(posedge clk)
    if (txValid === 1'b1 && txReady) q.push_back(txByte);
  always @(negedge clk)
    txReady <= slow ? ~txReady : 1'b1;
endmodule : fcd_master_model
`default_nettype wire

/* test/testbench.sv */
// Purpose: Self-checking bench for the command decoder.
// Assumes: All selects on bus, inputs idle.
// Notes:   Shadow memory predicts every read.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] FOLLOWER = 8'h21;
  typedef logic [7:0] fcd_bq_t[$];
  logic clk, rst_n, rxValid, rxFrameEnd, txValid, txReady;
  logic [7:0] rxByte, txByte, dcCurrentCmd;
  fcd_pkg::fcd_drive_cmd_t cmd, seen;
  logic [15:0] mem[64];
  logic [15:0] w, lastW = 16'h003C;
  int seed = 64, errTotal = 0, testsRun = 0, trips = 0, expTrips = 0;
  fcd_decoder #(.TICK_CYCLES(4)) fcd_decoder_inst (.clk, .rst_n, .followerAddr(FOLLOWER), .rxByte,
    .rxValid, .rxFrameEnd, .txByte, .txValid, .txReady, .din(6'h3F), .selCfg(6'h15),
    .dcHoldCurrent(8'h5A), .dcHoldDuration(16'h0003), .cmd, .dcCurrentCmd);
  fcd_master_model fcd_master_model_inst (.clk, .rxByte, .rxValid, .rxFrameEnd, .txByte, .txValid, .txReady);
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
    if (cmd.tripReset === 1'b1) trips++;
  // ==========
  // Prediction
  function automatic logic [15:0] crc(fcd_bq_t f);
    logic [15:0] c = 16'hFFFF;
    foreach (f[i])
    begin
      c ^= {8'h00, f[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc
  // Brake, stop and reset pulse fields are left to the checker
  function automatic fcd_pkg::fcd_drive_cmd_t expCmd(logic [15:0] v);
    expCmd = '0;
    expCmd.presetSel = v[1:0];
    expCmd.coast = !v[3];
    expCmd.quickStop = !v[4] && v[5];
    expCmd.holdFreq = !v[5];
    expCmd.rampStop = !v[6] && v[5];
    {expCmd.ramp2, expCmd.jog} = {v[9], v[8]};
    {expCmd.reverse, expCmd.setup, expCmd.relay2, expCmd.relay1} = v[15:11];
  endfunction : expCmd
  // ==========
  // Checking and transfers
  task automatic endSim();
    if (errTotal == 0 && testsRun > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : endSim
  task automatic check(logic [31:0] s, logic [31:0] e);
    testsRun++;
    if (s !== e)
    begin
      errTotal++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic xact(fcd_bq_t f, fcd_bq_t e, logic bad);
    logic [15:0] c = crc(f);
    int t;
    f = {f, c[7:0] ^ {7'h00, bad}, c[15:8]};
    c = crc(e);
    if (e.size() > 0) e = {e, c[7:0], c[15:8]};
    fcd_master_model_inst.q.delete();
    fcd_master_model_inst.send(f);
    for (t = 0; t < 800 && fcd_master_model_inst.q.size() < e.size(); t++) @(negedge clk);
    if (t == 800) check(0, 1);
    if (t == 800) endSim();
    repeat (40) @(negedge clk);
    check(fcd_master_model_inst.q.size(), e.size());
    foreach (e[i]) if (i < fcd_master_model_inst.q.size()) check(fcd_master_model_inst.q[i], e[i]);
  endtask : xact
  task automatic preset(logic [7:0] ad, logic [7:0] st, int n, logic [15:0] v0, logic bad);
    fcd_bq_t f, e;
    logic [15:0] v;
    logic ok = ad == FOLLOWER && !bad && n > 0 && n <= 8 && st + n <= 64;
    f = {ad, 8'h10, 8'h00, st, 8'h00, 8'(n), 8'(2 * n)};
    if (ok) e = f[0:5];
    for (int i = 0; i < n; i++)
    begin
      v = i == 0 ? v0 : 16'($random(seed));
      f = {f, v[15:8], v[7:0]};
      if (ok) mem[st + i] = v;
    end
    if (ok && st == 0 && v0[10]) expTrips += int'(v0[7] && !lastW[7]);
    if (ok && st == 0 && v0[10]) lastW = v0;
    xact(f, e, bad);
  endtask : preset
  task automatic rdwr(logic [7:0] rs, int rn, logic [7:0] ws, int wn);
    fcd_bq_t f, e;
    logic [15:0] v;
    f = {FOLLOWER, 8'h17, 8'h00, rs, 8'h00, 8'(rn), 8'h00, ws, 8'h00, 8'(wn), 8'(2 * wn)};
    for (int i = 0; i < wn; i++)
    begin
      v = $random(seed);
      f = {f, v[15:8], v[7:0]};
      mem[ws + i] = v;
    end
    e = {FOLLOWER, 8'h17, 8'(2 * rn)};
    for (int i = 0; i < rn; i++) e = {e, mem[rs + i][15:8], mem[rs + i][7:0]};
    xact(f, e, 1'b0);
  endtask : rdwr
  // ==========
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    preset(FOLLOWER, 8'h01, 8, 16'h1234, 1'b0);
    preset(FOLLOWER, 8'h3E, 2, 16'hBEEF, 1'b0);
    for (int k = 0; k < 12; k++)
    begin
      fcd_master_model_inst.slow = k[0];
      w = $random(seed);
      w[10] = k % 3 != 2;
      preset(FOLLOWER, 8'h00, 1, w, 1'b0);
      seen = cmd;
      {seen.dcBrake, seen.dcStop, seen.tripReset} = 3'h0;
      check(seen, expCmd(lastW));
      rdwr(8'h01 + 8'(k % 4), 2, 8'h02 + 8'(k % 4), k % 3 + 1);
    end
    preset(FOLLOWER, 8'h05, 1, 16'h0000, 1'b1); // Corrupt check bytes
    preset(8'h22, 8'h05, 1, 16'h0000, 1'b0);
    preset(FOLLOWER, 8'h05, 9, 16'h0000, 1'b0);
    preset(FOLLOWER, 8'h3F, 2, 16'h0000, 1'b0);
    rdwr(8'h05, 1, 8'h06, 1);
    check(trips, expTrips);
    endSim();
  end
endmodule : testbench
`default_nettype wire
